//--- hdl/uart_pin_pkg.sv
package uart_pin_pkg;

   // ----------------------------------------------------------------
   // channel count and register layout
   // ----------------------------------------------------------------
   localparam int unsigned NUM_CHAN = 4;
   localparam logic [1:0] OFF_MODEM_CTRL = 2'h0;
   localparam logic [1:0] OFF_ENH_FEATURE = 2'h1;
   localparam logic [1:0] OFF_IRQ_ENABLE = 2'h2;
   localparam logic [1:0] OFF_PIN_STATUS = 2'h3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic [3:0] SERIAL_OUT_RESET = 4'hF;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned MCR_DTR_BIT = 0;
   localparam int unsigned MCR_RTS_BIT = 1;
   localparam int unsigned MCR_IRQ_EN_BIT = 3;
   localparam int unsigned MCR_IR_MODE_BIT = 6;
   localparam int unsigned EFR_AUTO_RTS_BIT = 6;
   localparam int unsigned EFR_AUTO_CTS_BIT = 7;
   localparam int unsigned STAT_CTS_BIT = 0;
   localparam int unsigned STAT_DSR_BIT = 1;
   localparam int unsigned STAT_TX_OK_BIT = 2;
   localparam int unsigned STAT_STROBE_BIT = 3;
   localparam int unsigned STAT_IR_BIT = 4;

   // ----------------------------------------------------------------
   // infrared pulse timing, in baud ticks (16 per bit)
   // ----------------------------------------------------------------
   localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
   localparam logic [4:0] IR_BIT_TICKS = 5'h10;
   localparam logic [3:0] TICK_CNT_RESET = 4'h0;
   localparam logic [4:0] DEC_CNT_RESET = 5'h00;

   // per-channel software settings
   typedef struct packed {
      logic [7:0] modem_control_reg;
      logic [7:0] enhanced_feature_reg;
      logic [7:0] interrupt_enable_reg;
   } chan_ctrl_s;

   localparam chan_ctrl_s CHAN_CTRL_RESET = '{CTRL_RESET, CTRL_RESET, CTRL_RESET};

endpackage

//--- hdl/ir_pulse_encoder.sv
`timescale 1ns/100ps
module ir_pulse_encoder (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // bit timing and data
   input wire logic i_tick,
   input wire logic i_nrz,
   // encoded pulse
   output logic o_pulse
);

   logic nrz_prev_reg;
   logic nrz_prev_next;
   logic [3:0] tick_cnt_reg;
   logic [3:0] tick_cnt_next;
   logic pulse_reg;
   logic pulse_next;

   // a zero bit becomes a short high pulse; a one bit and idle stay low
   always_comb begin
      nrz_prev_next = i_nrz;
      tick_cnt_next = tick_cnt_reg;
      if (i_nrz != nrz_prev_reg) begin
         tick_cnt_next = uart_pin_pkg::TICK_CNT_RESET;
      end else if (i_tick) begin
         tick_cnt_next = tick_cnt_reg + 4'h1;
      end
      pulse_next = !i_nrz && (tick_cnt_next < uart_pin_pkg::IR_PULSE_TICKS);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         nrz_prev_reg <= 1'b1;
         tick_cnt_reg <= uart_pin_pkg::TICK_CNT_RESET;
         pulse_reg <= 1'b0;
      end else if (i_ce) begin
         nrz_prev_reg <= nrz_prev_next;
         tick_cnt_reg <= tick_cnt_next;
         pulse_reg <= pulse_next;
      end
   end

   assign o_pulse = pulse_reg;

endmodule

//--- hdl/ir_pulse_decoder.sv
`timescale 1ns/100ps
module ir_pulse_decoder (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // bit timing and pin
   input wire logic i_tick,
   input wire logic i_pulse,
   // decoded data, idles high
   output logic o_nrz
);

   logic pulse_prev_reg;
   logic pulse_prev_next;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic nrz_reg;
   logic nrz_next;

   // a rising pulse edge stretches into one low bit time
   always_comb begin
      pulse_prev_next = i_pulse;
      cnt_next = cnt_reg;
      if (i_pulse && !pulse_prev_reg) begin
         cnt_next = uart_pin_pkg::IR_BIT_TICKS;
      end else if (i_tick && (cnt_reg != uart_pin_pkg::DEC_CNT_RESET)) begin
         cnt_next = cnt_reg - 5'h01;
      end
      nrz_next = (cnt_next == uart_pin_pkg::DEC_CNT_RESET);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pulse_prev_reg <= 1'b0;
         cnt_reg <= uart_pin_pkg::DEC_CNT_RESET;
         nrz_reg <= 1'b1;
      end else if (i_ce) begin
         pulse_prev_reg <= pulse_prev_next;
         cnt_reg <= cnt_next;
         nrz_reg <= nrz_next;
      end
   end

   assign o_nrz = nrz_reg;

endmodule

//--- hdl/uart_pin_select.sv
// Function
// - Strobe-style host bus is used while the bus-type pin is high, read/write-line bus when low.
// - The interrupt-output select input is active high and reads low when left undriven.
// - In strobe mode with the select input high, all four interrupt outputs are driven always.
// - In strobe mode with the select input low, a channel interrupt drives only while its bit 3 is one.
// - While that bit 3 is zero, its default, the channel interrupt output is high impedance.
// - With bit 6 clear a channel uses plain NRZ serial, its output high in reset and when idle.
// - In infrared mode the idle level of the encoded output and of the pin input is low.
// - Clear-to-send is a plain input, or gates transmission when feature bit 7 is set.
// - Each channel has an active-low terminal-ready output under software control.
// - The set-ready input is status only and never affects transmit or receive.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module uart_pin_select (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // straps
   input wire logic i_bus_strobe_mode,
   input wire logic i_irq_output_select_pin,
   // register port
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // uart core side
   input wire logic i_baud_tick,
   input wire logic [3:0] i_core_irq,
   input wire logic [3:0] i_core_tx,
   input wire logic [3:0] i_rx_halt,
   output logic [3:0] o_core_rx,
   output logic [3:0] o_tx_allowed,
   // serial and modem pins
   output logic [3:0] o_serial_out,
   input wire logic [3:0] i_serial_in,
   output logic [3:0] o_request_to_send_n,
   input wire logic [3:0] i_clear_to_send_n,
   output logic [3:0] o_terminal_ready_n,
   input wire logic [3:0] i_set_ready_n,
   // interrupt pins
   output logic [3:0] o_channel_irq_out,
   output logic [3:0] o_channel_irq_oe_n
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   uart_pin_pkg::chan_ctrl_s ctrl_reg [3:0];
   uart_pin_pkg::chan_ctrl_s ctrl_next [3:0];
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [3:0] serial_out_reg;
   logic [3:0] serial_out_next;
   logic [3:0] core_rx_reg;
   logic [3:0] core_rx_next;
   logic [3:0] tx_ok_reg;
   logic [3:0] tx_ok_next;
   logic [3:0] rts_n_reg;
   logic [3:0] rts_n_next;
   logic [3:0] dtr_n_reg;
   logic [3:0] dtr_n_next;
   logic [3:0] irq_out_reg;
   logic [3:0] irq_out_next;
   logic [3:0] irq_oe_n_reg;
   logic [3:0] irq_oe_n_next;

   // per-channel views of the settings
   logic [3:0] irq_en_bit;
   logic [3:0] ir_mode_bit;
   logic [3:0] rts_bit;
   logic [3:0] dtr_bit;
   logic [3:0] auto_rts_bit;
   logic [3:0] auto_cts_bit;
   logic [3:0] enc_pulse;
   logic [3:0] dec_nrz;
   logic [1:0] sel_chan;
   logic [1:0] sel_reg;
   logic irq_select;

   assign sel_chan = i_addr[3:2];
   assign sel_reg = i_addr[1:0];
   // pull-down lives in the pad; an undriven pin arrives here as low
   assign irq_select = i_irq_output_select_pin;

   // ----------------------------------------------------------------
   // per-channel coders and setting views
   // ----------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : g_chan
         assign irq_en_bit[ch] = ctrl_reg[ch].modem_control_reg[uart_pin_pkg::MCR_IRQ_EN_BIT];
         assign ir_mode_bit[ch] = ctrl_reg[ch].modem_control_reg[uart_pin_pkg::MCR_IR_MODE_BIT];
         assign rts_bit[ch] = ctrl_reg[ch].modem_control_reg[uart_pin_pkg::MCR_RTS_BIT];
         assign dtr_bit[ch] = ctrl_reg[ch].modem_control_reg[uart_pin_pkg::MCR_DTR_BIT];
         assign auto_rts_bit[ch] = ctrl_reg[ch].enhanced_feature_reg[uart_pin_pkg::EFR_AUTO_RTS_BIT];
         assign auto_cts_bit[ch] = ctrl_reg[ch].enhanced_feature_reg[uart_pin_pkg::EFR_AUTO_CTS_BIT];

         // both coders run always; the mux below picks per mode
         ir_pulse_encoder u_enc (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_ce(i_ce),
            .i_tick(i_baud_tick),
            .i_nrz(i_core_tx[ch]),
            .o_pulse(enc_pulse[ch])
         );

         ir_pulse_decoder u_dec (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_ce(i_ce),
            .i_tick(i_baud_tick),
            .i_pulse(i_serial_in[ch]),
            .o_nrz(dec_nrz[ch])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // register writes and reads
   // ----------------------------------------------------------------
   // each channel owns its own copy; a write touches one channel only
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         ctrl_next[i] = ctrl_reg[i];
      end
      rdata_next = uart_pin_pkg::RDATA_RESET; // read data stand one cycle only
      if (i_wr) begin
         unique case (sel_reg)
            uart_pin_pkg::OFF_MODEM_CTRL: ctrl_next[sel_chan].modem_control_reg = i_wdata;
            uart_pin_pkg::OFF_ENH_FEATURE: ctrl_next[sel_chan].enhanced_feature_reg = i_wdata;
            uart_pin_pkg::OFF_IRQ_ENABLE: ctrl_next[sel_chan].interrupt_enable_reg = i_wdata;
            uart_pin_pkg::OFF_PIN_STATUS: ; // read-only
         endcase
      end
      if (i_rd) begin
         unique case (sel_reg)
            uart_pin_pkg::OFF_MODEM_CTRL: rdata_next = ctrl_reg[sel_chan].modem_control_reg;
            uart_pin_pkg::OFF_ENH_FEATURE: rdata_next = ctrl_reg[sel_chan].enhanced_feature_reg;
            uart_pin_pkg::OFF_IRQ_ENABLE: rdata_next = ctrl_reg[sel_chan].interrupt_enable_reg;
            uart_pin_pkg::OFF_PIN_STATUS: begin
               // set-ready is visible here and nowhere else
               rdata_next[uart_pin_pkg::STAT_CTS_BIT] = i_clear_to_send_n[sel_chan];
               rdata_next[uart_pin_pkg::STAT_DSR_BIT] = i_set_ready_n[sel_chan];
               rdata_next[uart_pin_pkg::STAT_TX_OK_BIT] = tx_ok_reg[sel_chan];
               rdata_next[uart_pin_pkg::STAT_STROBE_BIT] = i_bus_strobe_mode;
               rdata_next[uart_pin_pkg::STAT_IR_BIT] = ir_mode_bit[sel_chan];
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin next values
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         // nrz passes straight; infrared swaps in the coders
         serial_out_next[i] = ir_mode_bit[i] ? enc_pulse[i] : i_core_tx[i];
         core_rx_next[i] = ir_mode_bit[i] ? dec_nrz[i] : i_serial_in[i];
         // set-ready deliberately absent from this term
         tx_ok_next[i] = !(auto_cts_bit[i] && i_clear_to_send_n[i]);
         // auto mode can only release a line software already asserted
         rts_n_next[i] = !rts_bit[i] || (auto_rts_bit[i] && i_rx_halt[i]);
         dtr_n_next[i] = !dtr_bit[i];
         if (i_bus_strobe_mode) begin
            // select pin overrides bit 3 and drives all four
            irq_out_next[i] = i_core_irq[i];
            irq_oe_n_next[i] = !(irq_select || irq_en_bit[i]);
         end else begin
            // one shared open-drain low for the device, others held at zero
            irq_out_next[i] = 1'b0;
            irq_oe_n_next[i] = (i == 0) ? !(|i_core_irq) : 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < 4; i++) begin
            ctrl_reg[i] <= uart_pin_pkg::CHAN_CTRL_RESET;
         end
         rdata_reg <= uart_pin_pkg::RDATA_RESET;
         serial_out_reg <= uart_pin_pkg::SERIAL_OUT_RESET;
         core_rx_reg <= 4'hF;
         tx_ok_reg <= 4'hF;
         rts_n_reg <= 4'hF;
         dtr_n_reg <= 4'hF;
         irq_out_reg <= 4'h0;
         irq_oe_n_reg <= 4'hF;
      end else if (i_ce) begin
         for (int i = 0; i < 4; i++) begin
            ctrl_reg[i] <= ctrl_next[i];
         end
         rdata_reg <= rdata_next;
         serial_out_reg <= serial_out_next;
         core_rx_reg <= core_rx_next;
         tx_ok_reg <= tx_ok_next;
         rts_n_reg <= rts_n_next;
         dtr_n_reg <= dtr_n_next;
         irq_out_reg <= irq_out_next;
         irq_oe_n_reg <= irq_oe_n_next;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_serial_out = serial_out_reg;
   assign o_core_rx = core_rx_reg;
   assign o_tx_allowed = tx_ok_reg;
   assign o_request_to_send_n = rts_n_reg;
   assign o_terminal_ready_n = dtr_n_reg;
   assign o_channel_irq_out = irq_out_reg;
   assign o_channel_irq_oe_n = irq_oe_n_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_rw_mode_irq: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !i_bus_strobe_mode)
      |=> (o_channel_irq_out == 4'h0) && (o_channel_irq_oe_n[3:1] == 3'h0))
      else $error("read/write-line mode interrupt pins wrong");

   a_select_drives_all: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_bus_strobe_mode && i_irq_output_select_pin)
      |=> (o_channel_irq_oe_n == 4'h0))
      else $error("select high but interrupt outputs not driven");

   a_bit3_gates_irq: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_bus_strobe_mode && !i_irq_output_select_pin && irq_en_bit[2])
      |=> (!o_channel_irq_oe_n[2] && (o_channel_irq_out[2] == $past(i_core_irq[2]))))
      else $error("interrupt not driven with bit 3 set");

   a_bit3_clear_float: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_bus_strobe_mode && !i_irq_output_select_pin && !irq_en_bit[1])
      |=> o_channel_irq_oe_n[1])
      else $error("interrupt driven with bit 3 clear");

   a_nrz_serial_out: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !ir_mode_bit[0]) |=> (o_serial_out[0] == $past(i_core_tx[0])))
      else $error("nrz serial output does not follow core");

   a_ir_route_out: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && ir_mode_bit[3]) |=> (o_serial_out[3] == $past(enc_pulse[3])))
      else $error("infrared output not from encoder");

   a_ir_idle_low: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && ir_mode_bit[0] && i_core_tx[0]) ##1 (i_ce && ir_mode_bit[0])
      |=> !o_serial_out[0])
      else $error("infrared idle level not low");

   a_auto_cts_gate: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && auto_cts_bit[1] && i_clear_to_send_n[1]) |=> !o_tx_allowed[1])
      else $error("transmit not gated by clear-to-send");

   a_dtr_follows: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      i_ce |=> (o_terminal_ready_n == ~$past(dtr_bit)))
      else $error("terminal-ready does not follow bit 0");

   a_dsr_no_effect: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !auto_cts_bit[0]) |=> o_tx_allowed[0])
      else $error("transmit blocked without auto clear-to-send");

   a_chan_isolated: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_wr && (i_addr[3:2] != 2'h0)) |=> (ctrl_reg[0] == $past(ctrl_reg[0])))
      else $error("write to another channel changed channel 0");

   a_auto_rts_release: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && auto_rts_bit[2] && i_rx_halt[2]) |=> o_request_to_send_n[2])
      else $error("auto request-to-send did not release the line");

   a_ir_route_in: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && ir_mode_bit[2]) |=> (o_core_rx[2] == $past(dec_nrz[2])))
      else $error("infrared receive not from decoder");

   a_nrz_serial_in: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !ir_mode_bit[1]) |=> (o_core_rx[1] == $past(i_serial_in[1])))
      else $error("nrz receive does not follow serial input");

endmodule

//--- tb/remote_serial_model.sv
`timescale 1ns/100ps
module remote_serial_model (
   // clock
   input wire logic i_clk,
   // far-side control from the bench
   input wire logic [3:0] i_ir_mode,
   input wire logic [3:0] i_fire,
   // pins into the block
   output logic [3:0] o_serial_in,
   output logic [3:0] o_clear_to_send_n,
   output logic [3:0] o_set_ready_n
);
   // ------------------------------------------------
   // remote line drivers
   // ------------------------------------------------
   int seed = 32'hFF7E;
   logic [31:0] r;
   // start idle so the block never sees a false start bit
   initial begin
      o_serial_in = 4'hF;
      o_clear_to_send_n = 4'hF;
      o_set_ready_n = 4'hF;
   end
   // nrz lines idle high between bursts; infrared lines idle low, pulse only on command
   always @(posedge i_clk) begin
      r = $random(seed);
      o_serial_in <= (i_ir_mode & i_fire) | (~i_ir_mode & (r[3:0] | {4{r[4]}}));
      o_clear_to_send_n <= r[11:8];
      o_set_ready_n <= r[15:12];
   end
endmodule

//--- tb/uart_pin_select_tb.sv
`timescale 1ns/100ps
module uart_pin_select_tb;
   // ------------------------------------------------
   // signals
   // ------------------------------------------------
   logic i_clk, i_rst_n, i_ce, i_bus_strobe_mode, i_irq_output_select_pin;
   logic i_wr, i_rd, i_baud_tick, run;
   logic [3:0] i_addr, i_core_irq, i_core_tx, i_rx_halt, fire, i_serial_in;
   logic [3:0] o_core_rx, o_tx_allowed, o_serial_out, o_request_to_send_n;
   logic [3:0] i_clear_to_send_n, o_terminal_ready_n, i_set_ready_n, o_channel_irq_out;
   logic [3:0] o_channel_irq_oe_n, e_sout, e_rx, e_txok, e_rts, e_dtr, e_irq, e_oe, e_skip;
   logic [7:0] i_wdata, o_rdata, e_rdata, m, f;
   logic [7:0] modem_control_reg [4];
   logic [7:0] enhanced_feature_reg [4];
   logic [7:0] interrupt_enable_reg [4];
   logic [31:0] r;
   int err_count, n_compared, seed, k;

   uart_pin_select uart_pin_select_i (
      .i_clk, .i_rst_n, .i_ce, .i_bus_strobe_mode, .i_irq_output_select_pin,
      .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_baud_tick, .i_core_irq,
      .i_core_tx, .i_rx_halt, .o_core_rx, .o_tx_allowed, .o_serial_out, .i_serial_in,
      .o_request_to_send_n, .i_clear_to_send_n, .o_terminal_ready_n, .i_set_ready_n,
      .o_channel_irq_out, .o_channel_irq_oe_n
   );

   remote_serial_model remote_serial_model_i (
      .i_clk, .i_ir_mode(e_skip), .i_fire(fire), .o_serial_in(i_serial_in),
      .o_clear_to_send_n(i_clear_to_send_n), .o_set_ready_n(i_set_ready_n)
   );

   // 250 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   // ------------------------------------------------
   // reference model
   // ------------------------------------------------
   // shadow registers; every pin is one flop after its cause
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int c = 0; c < 4; c++) begin
            modem_control_reg[c] = 8'h00;
            enhanced_feature_reg[c] = 8'h00;
            interrupt_enable_reg[c] = 8'h00;
         end
         e_rdata = 8'h00;
         {e_sout, e_rx, e_txok, e_rts, e_dtr, e_oe} = 24'hFFFFFF;
         e_irq = 4'h0;
         e_skip <= 4'h0;
      end else if (i_ce) begin
         m = modem_control_reg[i_addr[3:2]];
         e_rdata = 8'h00;
         // status uses the tx-allowed flop before this edge updates it
         if (i_rd) begin
            case (i_addr[1:0])
               2'h0: e_rdata = m;
               2'h1: e_rdata = enhanced_feature_reg[i_addr[3:2]];
               2'h2: e_rdata = interrupt_enable_reg[i_addr[3:2]];
               default: e_rdata = {3'h0, m[6], i_bus_strobe_mode, e_txok[i_addr[3:2]],
                  i_set_ready_n[i_addr[3:2]], i_clear_to_send_n[i_addr[3:2]]};
            endcase
         end
         // nonblocking so the remote model reads it without a race
         e_skip <= {modem_control_reg[3][6], modem_control_reg[2][6], modem_control_reg[1][6], modem_control_reg[0][6]};
         for (int c = 0; c < 4; c++) begin
            m = modem_control_reg[c];
            f = enhanced_feature_reg[c];
            e_sout[c] = i_core_tx[c];
            e_rx[c] = i_serial_in[c];
            e_txok[c] = ~(f[7] & i_clear_to_send_n[c]);
            e_rts[c] = ~m[1] | (f[6] & i_rx_halt[c]);
            e_dtr[c] = ~m[0];
            e_irq[c] = i_bus_strobe_mode & i_core_irq[c];
            e_oe[c] = i_bus_strobe_mode ? ~(i_irq_output_select_pin | m[3]) :
               ((c == 0) ? ~|i_core_irq : 1'b0);
         end
         if (i_wr) begin
            case (i_addr[1:0])
               2'h0: modem_control_reg[i_addr[3:2]] = i_wdata;
               2'h1: enhanced_feature_reg[i_addr[3:2]] = i_wdata;
               2'h2: interrupt_enable_reg[i_addr[3:2]] = i_wdata;
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------
   // checking
   // ------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // compare at the falling edge, when every flop has settled
   always @(negedge i_clk) begin
      if (run) begin
         check(o_rdata, e_rdata);
         check({4'h0, o_serial_out & ~e_skip}, {4'h0, e_sout & ~e_skip});
         check({4'h0, o_core_rx & ~e_skip}, {4'h0, e_rx & ~e_skip});
         check({4'h0, o_tx_allowed}, {4'h0, e_txok});
         check({4'h0, o_request_to_send_n}, {4'h0, e_rts});
         check({4'h0, o_terminal_ready_n}, {4'h0, e_dtr});
         check({4'h0, o_channel_irq_oe_n}, {4'h0, e_oe});
         check({4'h0, o_channel_irq_out & ~e_oe}, {4'h0, e_irq & ~e_oe});
      end
   end

   // ------------------------------------------------
   // stimulus
   // ------------------------------------------------
   task automatic wr_reg(input logic [3:0] addr, input logic [7:0] data);
      @(posedge i_clk);
      i_ce <= 1'b1;
      i_wr <= 1'b1;
      i_rd <= 1'b0;
      i_addr <= addr;
      i_wdata <= data;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // one baud tick every other cycle, sampled once settled
   task automatic tick_cycle();
      @(posedge i_clk);
      i_baud_tick <= ~i_baud_tick;
      @(negedge i_clk);
   endtask

   // random traffic; infrared stays off so nrz results stay exact
   task automatic rand_phase(input int n, input logic strobe);
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk);
         r = $random(seed);
         i_ce <= (r[3:0] != 4'h0);
         i_wr <= (r[5:4] == 2'h1);
         i_rd <= (r[5:4] == 2'h2);
         i_addr <= r[9:6];
         i_wdata <= (r[7:6] == 2'h0) ? (r[17:10] & 8'hBF) : r[17:10];
         i_core_irq <= r[21:18];
         i_core_tx <= r[25:22];
         i_rx_halt <= r[29:26];
         i_baud_tick <= r[30];
         i_bus_strobe_mode <= strobe;
         // select stays low on the read/write-line bus
         if (!strobe || (r[31] & r[2] & r[1])) begin
            i_irq_output_select_pin <= strobe & ~i_irq_output_select_pin;
         end
      end
   endtask

   // main sequence
   initial begin
      seed = 32'hFF7E;
      {i_ce, i_wr, i_rd, i_baud_tick, run} = 5'h10;
      {i_bus_strobe_mode, i_irq_output_select_pin} = 2'h2;
      {i_addr, i_core_irq, i_core_tx, i_rx_halt, fire} = 20'h00F00;
      i_wdata = 8'h00;
      err_count = 0;
      n_compared = 0;
      i_rst_n = 1'b0;
      @(posedge i_clk);
      run = 1'b1;
      repeat (11) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(negedge i_clk);
      check({4'h0, o_channel_irq_oe_n}, 8'h0F);
      rand_phase(3000, 1'b1);
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rand_phase(2000, 1'b0);
      // one clean edge so no signal is driven twice in one step
      @(posedge i_clk);
      i_ce <= 1'b1;
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      i_bus_strobe_mode <= 1'b1;
      i_core_tx <= 4'hF;
      // infrared on channels 0, 3 and 2; 2 is the one probed below
      wr_reg(4'h0, 8'h40);
      wr_reg(4'hC, 8'h40);
      wr_reg(4'h8, 8'h40);
      repeat (40) tick_cycle();
      check({7'h00, o_serial_out[2]}, 8'h00);
      check({7'h00, o_core_rx[2]}, 8'h01);
      @(posedge i_clk);
      i_core_tx <= 4'hB;
      for (k = 0; k < 100 && o_serial_out[2] !== 1'b1; k++) tick_cycle();
      check({7'h00, o_serial_out[2]}, 8'h01);
      if (k == 100) err_count++;
      @(posedge i_clk);
      i_core_tx <= 4'hF;
      fire <= 4'h4;
      repeat (2) tick_cycle();
      @(posedge i_clk);
      fire <= 4'h0;
      for (k = 0; k < 100 && o_core_rx[2] !== 1'b0; k++) tick_cycle();
      check({7'h00, o_core_rx[2]}, 8'h00);
      if (k == 100) err_count++;
      summarize();
   end
endmodule
